// [logic/cdcd_pkg.sv]
// constants shared by the character display command decoder and its memory
package cdcd_pkg;

    // wishbone register byte offsets
    localparam logic [3:0] OFF_INSTR = 4'h0;  // instruction port, rs low
    localparam logic [3:0] OFF_DATA  = 4'h4;  // ram data port, rs high
    localparam logic [3:0] OFF_MODE  = 4'h8;  // mode bits, read only
    localparam logic [3:0] OFF_SHIFT = 4'hc;  // display shift offset

    // memory geometry
    localparam int CHAR_AW  = 7;
    localparam int GLYPH_AW = 6;

    // character codes and address counter boundaries
    localparam logic [7:0] SPACE_CODE    = 8'h20;
    localparam logic [6:0] CHAR_HOME     = 7'h00;
    localparam logic [6:0] CHAR_L1_LAST  = 7'h27;
    localparam logic [6:0] CHAR_L2_FIRST = 7'h40;
    localparam logic [6:0] CHAR_L2_LAST  = 7'h67;
    localparam logic [5:0] GLYPH_LAST    = 6'h3f;
    localparam logic [5:0] SHIFT_LAST    = 6'h27;  // 40 columns per line

    // instruction opcode marker positions (most significant set bit)
    localparam int OP_CLEAR_BIT = 0;
    localparam int OP_HOME_BIT  = 1;
    localparam int OP_ENTRY_BIT = 2;
    localparam int OP_DISP_BIT  = 3;
    localparam int OP_SHIFT_BIT = 4;
    localparam int OP_FUNC_BIT  = 5;
    localparam int OP_GLYPH_BIT = 6;
    localparam int OP_CHAR_BIT  = 7;

    // instruction field positions
    localparam int ENTRY_INCR_BIT  = 1;
    localparam int ENTRY_SHIFT_BIT = 0;
    localparam int DISP_ON_BIT     = 2;
    localparam int DISP_CUR_BIT    = 1;
    localparam int DISP_BLINK_BIT  = 0;
    localparam int SHIFT_DISP_BIT  = 3;
    localparam int SHIFT_UP_BIT    = 2;
    localparam int FUNC_WIDTH_BIT  = 4;
    localparam int FUNC_LINES_BIT  = 3;
    localparam int FUNC_LUM_HI_BIT = 1;
    localparam int FUNC_LUM_LO_BIT = 0;
    localparam int BUSY_BIT        = 7;

    // mode register field positions
    localparam int MODE_INCR_BIT   = 0;
    localparam int MODE_ASHIFT_BIT = 1;
    localparam int MODE_DISP_BIT   = 2;
    localparam int MODE_CUR_BIT    = 3;
    localparam int MODE_BLINK_BIT  = 4;
    localparam int MODE_WIDTH_BIT  = 5;
    localparam int MODE_LINES_BIT  = 6;
    localparam int MODE_LUM_LO_BIT = 7;
    localparam int MODE_LUM_HI_BIT = 8;
    localparam int MODE_GLYPH_BIT  = 9;

    // power-up values of the mode bits
    localparam logic       RST_INCR   = 1'b1;
    localparam logic       RST_ASHIFT = 1'b0;
    localparam logic       RST_DISP   = 1'b0;
    localparam logic       RST_CUR    = 1'b0;
    localparam logic       RST_BLINK  = 1'b0;
    localparam logic       RST_WIDTH  = 1'b1;
    localparam logic       RST_LINES  = 1'b1;
    localparam logic [1:0] RST_LUM    = 2'h0;
    localparam logic [5:0] RST_SHIFT  = 6'h00;

    // blink timing: half of a 1 Hz period
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned BLINK_HALF_MS     = 500;
    localparam int unsigned BLINK_HALF_CYCLES =
        (CLK_HZ / 1000) * BLINK_HALF_MS;

endpackage : cdcd_pkg

// [logic/cdcd_ram.sv]
// byte-wide register memory with one write port, two read ports, bulk fill
`timescale 1ns/100ps
module cdcd_ram #(
    parameter int         AW   = 7,
    parameter logic [7:0] FILL = 8'h20
) (
    input  wire logic          clk_i,
    input  wire logic          fill_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_a_i,
    output logic      [7:0]    rdata_a_o,
    input  wire logic [AW-1:0] raddr_b_i,
    output logic      [7:0]    rdata_b_o
);
    localparam int DEPTH = 1 << AW;

    logic [7:0] mem [DEPTH];

    // flops, so a whole-array fill completes in one cycle with no busy time
    always_ff @(posedge clk_i) begin
        if (fill_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= FILL;
            end
        end else if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // asynchronous reads; the caller registers what it passes on
    assign rdata_a_o = mem[raddr_a_i];
    assign rdata_b_o = mem[raddr_b_i];

endmodule : cdcd_ram

// [logic/cdcd_decoder.sv]
// character display instruction interpreter behind a wishbone slave
`timescale 1ns/100ps

module cdcd_decoder
    import cdcd_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = cdcd_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [6:0]  scan_addr_i,
    output logic      [7:0]  scan_char_o,
    output logic             scan_cursor_o,
    output logic             scan_all_on_o,
    output logic             display_on_o,
    output logic             two_lines_o,
    output logic             bus_width_sel_o,
    output logic             luminance_hi_o,
    output logic             luminance_lo_o,
    output logic      [5:0]  shift_offset_o
);
    import cdcd_pkg::*;

    localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);

    typedef struct packed {
        logic [6:0]    addr_counter;
        logic          glyph_sel;     // counter targets glyph ram
        logic          incr;
        logic          auto_shift;
        logic          disp_on;
        logic          cur_on;
        logic          blink_on;
        logic          bus_width_sel;
        logic          two_lines;
        logic          luminance_hi;
        logic          luminance_lo;
        logic [5:0]    shift;
        logic [BW-1:0] blink_cnt;
        logic          blink_phase;
        logic          ack;
        logic [31:0]   dat;
        logic [7:0]    scan_char;
        logic          scan_cursor;
        logic          scan_all_on;
    } cdcd_state_t;

    cdcd_state_t state_reg;
    cdcd_state_t state_next;

    logic       req;
    logic       reg_select;
    logic       wr_instr;
    logic       wr_data;
    logic       rd_data;
    logic [7:0] instr;
    logic [7:0] char_rd;
    logic [7:0] char_scan_rd;
    logic [7:0] glyph_rd;
    logic [7:0] ram_rd;
    logic       char_we;
    logic       glyph_we;
    logic       char_fill;
    logic       scan_hit;

    // one step of the address counter with the two memories' wrap points
    function automatic logic [6:0] ac_step(input logic [6:0] ac,
                                           input logic       up,
                                           input logic       glyph);
        logic [6:0] r;
        r = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
        if (glyph) begin
            // six-bit arithmetic gives 3f->00 and 00->3f
            r = {1'b0, r[5:0]};
        end else if (up && ac == CHAR_L1_LAST) begin
            r = CHAR_L2_FIRST;
        end else if (up && ac == CHAR_L2_LAST) begin
            r = CHAR_HOME;
        end else if (!up && ac == CHAR_L2_FIRST) begin
            r = CHAR_L1_LAST;
        end else if (!up && ac == CHAR_HOME) begin
            r = CHAR_L2_LAST;
        end
        return r;
    endfunction : ac_step

    // text shift offset over the 40 columns of a line; left raises it
    function automatic logic [5:0] shift_step(input logic [5:0] off,
                                              input logic       left);
        logic [5:0] r;
        if (left) begin
            r = (off == SHIFT_LAST) ? 6'h00 : 6'(off + 6'h01);
        end else begin
            r = (off == 6'h00) ? SHIFT_LAST : 6'(off - 6'h01);
        end
        return r;
    endfunction : shift_step

    // bus decode: one access per wishbone cycle, acked the cycle after
    assign req        = cyc_i & stb_i & ~state_reg.ack;
    assign reg_select = (adr_i == OFF_DATA);
    assign wr_instr   = req & we_i & sel_i[0] & (adr_i == OFF_INSTR);
    assign wr_data    = req & we_i & sel_i[0] & reg_select;
    assign rd_data    = req & ~we_i & reg_select;
    assign instr      = dat_i[7:0];
    assign ram_rd     = state_reg.glyph_sel ? glyph_rd : char_rd;
    assign scan_hit   = (scan_addr_i == state_reg.addr_counter) &
                        ~state_reg.glyph_sel;

    // character codes: filled with space by reset or clear
    cdcd_ram #(
        .AW   (CHAR_AW),
        .FILL (SPACE_CODE)
    ) u_char_code_ram (
        .clk_i     (clk_i),
        .fill_i    (char_fill),
        .we_i      (char_we),
        .waddr_i   (state_reg.addr_counter),
        .wdata_i   (instr),
        .raddr_a_i (state_reg.addr_counter),
        .rdata_a_o (char_rd),
        .raddr_b_i (scan_addr_i),
        .rdata_b_o (char_scan_rd)
    );

    // glyph patterns survive clear and reset
    cdcd_ram #(
        .AW   (GLYPH_AW),
        .FILL (8'h00)
    ) u_glyph_pattern_ram (
        .clk_i     (clk_i),
        .fill_i    (1'b0),
        .we_i      (glyph_we),
        .waddr_i   (state_reg.addr_counter[5:0]),
        .wdata_i   (instr),
        .raddr_a_i (state_reg.addr_counter[5:0]),
        .rdata_a_o (glyph_rd),
        .raddr_b_i (state_reg.addr_counter[5:0]),
        .rdata_b_o ()
    );

    // next-state logic: bus answer, instruction decode, data port, blink
    always_comb begin
        state_next = state_reg;
        char_we    = 1'b0;
        glyph_we   = 1'b0;
        char_fill  = rst_i;

        // every access is answered next cycle, no busy wait exists
        state_next.ack = req;
        if (req && !we_i) begin
            case (adr_i)
                OFF_INSTR: begin
                    // busy is constant zero, counter below it
                    state_next.dat = {24'h0, 1'b0,
                                      state_reg.addr_counter};
                end
                OFF_DATA: begin
                    state_next.dat = {24'h0, ram_rd};
                end
                OFF_MODE: begin
                    state_next.dat = 32'h0;
                    state_next.dat[MODE_INCR_BIT]   = state_reg.incr;
                    state_next.dat[MODE_ASHIFT_BIT] = state_reg.auto_shift;
                    state_next.dat[MODE_DISP_BIT]   = state_reg.disp_on;
                    state_next.dat[MODE_CUR_BIT]    = state_reg.cur_on;
                    state_next.dat[MODE_BLINK_BIT]  = state_reg.blink_on;
                    state_next.dat[MODE_WIDTH_BIT]  =
                        state_reg.bus_width_sel;
                    state_next.dat[MODE_LINES_BIT]  = state_reg.two_lines;
                    state_next.dat[MODE_LUM_LO_BIT] =
                        state_reg.luminance_lo;
                    state_next.dat[MODE_LUM_HI_BIT] =
                        state_reg.luminance_hi;
                    state_next.dat[MODE_GLYPH_BIT]  = state_reg.glyph_sel;
                end
                OFF_SHIFT: begin
                    state_next.dat = {26'h0, state_reg.shift};
                end
                default: begin
                    state_next.dat = 32'h0;  // unmapped reads as zero
                end
            endcase
        end

        // instruction byte: highest set bit picks the command
        if (wr_instr) begin
            if (instr[OP_CHAR_BIT]) begin
                state_next.addr_counter = instr[6:0];
                state_next.glyph_sel    = 1'b0;
            end else if (instr[OP_GLYPH_BIT]) begin
                state_next.addr_counter = {1'b0, instr[5:0]};
                state_next.glyph_sel    = 1'b1;
            end else if (instr[OP_FUNC_BIT]) begin
                state_next.bus_width_sel = instr[FUNC_WIDTH_BIT];
                state_next.two_lines     = instr[FUNC_LINES_BIT];
                state_next.luminance_hi  = instr[FUNC_LUM_HI_BIT];
                state_next.luminance_lo  = instr[FUNC_LUM_LO_BIT];
            end else if (instr[OP_SHIFT_BIT]) begin
                // always stepped as char ram, leaving glyph mode
                state_next.glyph_sel    = 1'b0;
                state_next.addr_counter =
                    ac_step(state_reg.addr_counter,
                            instr[SHIFT_UP_BIT], 1'b0);
                if (instr[SHIFT_DISP_BIT]) begin
                    // up direction moves the text right
                    state_next.shift =
                        shift_step(state_reg.shift,
                                   ~instr[SHIFT_UP_BIT]);
                end
            end else if (instr[OP_DISP_BIT]) begin
                state_next.disp_on  = instr[DISP_ON_BIT];
                state_next.cur_on   = instr[DISP_CUR_BIT];
                state_next.blink_on = instr[DISP_BLINK_BIT];
            end else if (instr[OP_ENTRY_BIT]) begin
                state_next.incr       = instr[ENTRY_INCR_BIT];
                state_next.auto_shift = instr[ENTRY_SHIFT_BIT];
            end else if (instr[OP_HOME_BIT]) begin
                state_next.addr_counter = CHAR_HOME;
                state_next.glyph_sel    = 1'b0;
                state_next.shift        = RST_SHIFT;
            end else if (instr[OP_CLEAR_BIT]) begin
                char_fill               = 1'b1;
                state_next.addr_counter = CHAR_HOME;
                state_next.glyph_sel    = 1'b0;
                state_next.shift        = RST_SHIFT;
                state_next.incr         = 1'b1;
            end
        end

        // data write: store at the counter, then step and maybe shift
        if (wr_data) begin
            if (state_reg.glyph_sel) begin
                glyph_we = 1'b1;
            end else begin
                char_we = 1'b1;
                if (state_reg.auto_shift) begin
                    state_next.shift =
                        shift_step(state_reg.shift,
                                   state_reg.incr);
                end
            end
            state_next.addr_counter =
                ac_step(state_reg.addr_counter, state_reg.incr,
                        state_reg.glyph_sel);
        end

        // data read: step only; the shift is left alone on reads
        if (rd_data) begin
            state_next.addr_counter =
                ac_step(state_reg.addr_counter, state_reg.incr,
                        state_reg.glyph_sel);
        end

        // free-running half-period timer flips the blink phase
        if (state_reg.blink_cnt == BLINK_LAST) begin
            state_next.blink_cnt   = '0;
            state_next.blink_phase = ~state_reg.blink_phase;
        end else begin
            state_next.blink_cnt = BW'(state_reg.blink_cnt + 1'b1);
        end

        // scan port: registered code, cursor row and blink substitution
        state_next.scan_char   = char_scan_rd;
        state_next.scan_cursor = state_reg.disp_on & state_reg.cur_on &
                                 scan_hit;
        state_next.scan_all_on = state_reg.disp_on & state_reg.blink_on &
                                 state_reg.blink_phase & scan_hit;

        // synchronous power-up state
        if (rst_i) begin
            state_next               = '0;
            state_next.addr_counter  = CHAR_HOME;
            state_next.shift         = RST_SHIFT;
            state_next.incr          = RST_INCR;
            state_next.auto_shift    = RST_ASHIFT;
            state_next.disp_on       = RST_DISP;
            state_next.cur_on        = RST_CUR;
            state_next.blink_on      = RST_BLINK;
            state_next.bus_width_sel = RST_WIDTH;
            state_next.two_lines     = RST_LINES;
            state_next.luminance_hi  = RST_LUM[1];
            state_next.luminance_lo  = RST_LUM[0];
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        state_reg <= state_next;
    end

    // outputs straight from the state register
    assign dat_o           = state_reg.dat;
    assign ack_o           = state_reg.ack;
    assign scan_char_o     = state_reg.scan_char;
    assign scan_cursor_o   = state_reg.scan_cursor;
    assign scan_all_on_o   = state_reg.scan_all_on;
    assign display_on_o    = state_reg.disp_on;
    assign two_lines_o     = state_reg.two_lines;
    assign bus_width_sel_o = state_reg.bus_width_sel;
    assign luminance_hi_o  = state_reg.luminance_hi;
    assign luminance_lo_o  = state_reg.luminance_lo;
    assign shift_offset_o  = state_reg.shift;

endmodule : cdcd_decoder

// [bench/cdcd_decoder_sva.sv]
// port-level checks of the character display command decoder
`timescale 1ns/100ps
module cdcd_decoder_sva #(
    parameter int unsigned BLINK_HALF_CYCLES = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [6:0]  scan_addr_i,
    input wire logic [7:0]  scan_char_o,
    input wire logic        scan_cursor_o,
    input wire logic        scan_all_on_o,
    input wire logic        display_on_o,
    input wire logic        two_lines_o,
    input wire logic        bus_width_sel_o,
    input wire logic        luminance_hi_o,
    input wire logic        luminance_lo_o,
    input wire logic [5:0]  shift_offset_o
);
    import cdcd_pkg::*;
    logic ins_wr;
    // an instruction write taken at this edge
    assign ins_wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                    && adr_i == OFF_INSTR;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_busy_zero: assert property (ack_o && !$past(we_i)
        && $past(adr_i) == OFF_INSTR |-> !dat_o[BUSY_BIT])
        else $error("busy bit set");
    a_reset_modes: assert property ($past(rst_i) |-> two_lines_o
        && bus_width_sel_o && !display_on_o && !luminance_hi_o
        && !luminance_lo_o && shift_offset_o == RST_SHIFT)
        else $error("wrong power-up modes");
    a_func_set: assert property (ins_wr && dat_i[7:5] == 3'b001
        |=> {bus_width_sel_o, two_lines_o, luminance_hi_o, luminance_lo_o}
        == {$past(dat_i[4]), $past(dat_i[3]), $past(dat_i[1:0])})
        else $error("function set not applied");
    a_disp_ctrl: assert property (ins_wr && dat_i[7:3] == 5'b00001
        |=> display_on_o == $past(dat_i[2]))
        else $error("display bit not applied");
    a_home_unshift: assert property (ins_wr && dat_i[7:2] == 6'h00
        && dat_i[1:0] != 2'h0 |=> shift_offset_o == 6'h00)
        else $error("shift kept after home or clear");
    // reads never move the text, so a change needs a write
    a_shift_cause: assert property ($changed(shift_offset_o)
        |-> ack_o && $past(we_i))
        else $error("shift changed without a write");
endmodule : cdcd_decoder_sva

bind cdcd_decoder cdcd_decoder_sva #(
    .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) cdcd_decoder_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .scan_addr_i(scan_addr_i),
    .scan_char_o(scan_char_o), .scan_cursor_o(scan_cursor_o),
    .scan_all_on_o(scan_all_on_o), .display_on_o(display_on_o),
    .two_lines_o(two_lines_o), .bus_width_sel_o(bus_width_sel_o),
    .luminance_hi_o(luminance_hi_o), .luminance_lo_o(luminance_lo_o),
    .shift_offset_o(shift_offset_o));

// [bench/cdcd_scan_model.sv]
// display scan model: sweeps char ram and tallies cursor cells
`timescale 1ns/100ps
module cdcd_scan_model (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       cursor_i,
    input  wire logic       all_on_i,
    output logic      [6:0] scan_addr_o = 7'h00,
    output logic      [7:0] cur_cnt_o = 8'h00,
    output logic      [7:0] on_cnt_o = 8'h00
);
    // a 104-cell sweep meets the blink in the other phase on each pass
    always @(posedge clk_i) begin
        if (clr_i || scan_addr_o == 7'h67) begin
            scan_addr_o <= 7'h00;
        end else begin
            scan_addr_o <= scan_addr_o + 7'h01;
        end
        cur_cnt_o <= clr_i ? 8'h00 : cur_cnt_o + {7'h00, cursor_i};
        on_cnt_o  <= clr_i ? 8'h00 : on_cnt_o + {7'h00, all_on_i};
    end
endmodule : cdcd_scan_model

// [bench/cdcd_decoder_tb.sv]
// self-checking bench for the character display command decoder
`timescale 1ns/100ps
module cdcd_decoder_tb;
    import cdcd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic        clr = 1'b1;
    logic [31:0] dat_o;
    logic        ack_o, cur_o, on_o, disp_o, two_o, bw_o, lhi_o, llo_o;
    logic [6:0]  scan_a;
    logic [7:0]  cur_cnt, on_cnt, scan_char;
    logic [5:0]  shift_o;
    int          num_errors = 0;
    int          checks = 0;

    // 100 mhz clock
    always #5 clk_i = ~clk_i;

    cdcd_decoder #(.BLINK_HALF_CYCLES(8)) cdcd_decoder_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .dat_o(dat_o), .ack_o(ack_o), .scan_addr_i(scan_a),
        .scan_char_o(scan_char), .scan_cursor_o(cur_o),
        .scan_all_on_o(on_o),
        .display_on_o(disp_o), .two_lines_o(two_o),
        .bus_width_sel_o(bw_o), .luminance_hi_o(lhi_o),
        .luminance_lo_o(llo_o), .shift_offset_o(shift_o));
    cdcd_scan_model cdcd_scan_model_inst (
        .clk_i(clk_i), .clr_i(clr), .cursor_i(cur_o), .all_on_i(on_o),
        .scan_addr_o(scan_a), .cur_cnt_o(cur_cnt), .on_cnt_o(on_cnt));

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one classic cycle; ack and read data are taken at the same rising
    // edge, and only then is the request released
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        sel_i <= 4'h1;
        n = 0;
        // no busy polling: the bus answer alone paces the host
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        if (ack_o !== 1'b1) begin
            num_errors++;
            end_of_test();
        end else begin
            q = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [3:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        check(nm, q, exp);
    endtask : rd

    // main sequence: power-up, counter wraps, shifts, clear, modes, blink
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("mode", OFF_MODE, 32'h61);
        rd("shift", OFF_SHIFT, 32'h00);
        rd("ram0", OFF_DATA, 32'h20);
        rd("ac", OFF_INSTR, 32'h01);
        wr(OFF_INSTR, 8'ha7);
        wr(OFF_DATA, 8'h41);
        wr(OFF_DATA, 8'h42);
        rd("ac wrap", OFF_INSTR, 32'h41);
        wr(OFF_INSTR, 8'he7);
        wr(OFF_DATA, 8'h43);
        rd("ac top", OFF_INSTR, 32'h00);
        wr(OFF_INSTR, 8'h04);
        wr(OFF_INSTR, 8'hc0);
        rd("ram40", OFF_DATA, 32'h42);
        rd("ac down", OFF_INSTR, 32'h27);
        rd("mode dn", OFF_MODE, 32'h60);
        wr(OFF_INSTR, 8'h40);
        wr(OFF_DATA, 8'h0a);
        rd("gac down", OFF_INSTR, 32'h3f);
        rd("mode gl", OFF_MODE, 32'h260);
        wr(OFF_INSTR, 8'h06);
        wr(OFF_DATA, 8'h15);
        rd("gac up", OFF_INSTR, 32'h00);
        wr(OFF_INSTR, 8'h7f);
        rd("glyph", OFF_DATA, 32'h15);
        wr(OFF_INSTR, 8'h14);
        rd("ac sh", OFF_INSTR, 32'h01);
        rd("mode ch", OFF_MODE, 32'h61);
        wr(OFF_INSTR, 8'h07);
        wr(OFF_DATA, 8'h31);
        rd("ram2", OFF_DATA, 32'h20);
        rd("shl", OFF_SHIFT, 32'h01);
        wr(OFF_INSTR, 8'h05);
        wr(OFF_DATA, 8'h32);
        rd("shr", OFF_SHIFT, 32'h00);
        wr(OFF_INSTR, 8'h1c);
        rd("sh wrap", OFF_SHIFT, 32'h27);
        wr(OFF_INSTR, 8'h18);
        wr(OFF_INSTR, 8'h18);
        rd("sh left", OFF_SHIFT, 32'h01);
        wr(OFF_INSTR, 8'h03);
        rd("home sh", OFF_SHIFT, 32'h00);
        rd("home ac", OFF_INSTR, 32'h00);
        wr(OFF_INSTR, 8'h85);
        wr(OFF_DATA, 8'h55);
        wr(OFF_INSTR, 8'h01);
        rd("clr ac", OFF_INSTR, 32'h00);
        rd("clr sh", OFF_SHIFT, 32'h00);
        rd("clr md", OFF_MODE, 32'h63);
        wr(OFF_INSTR, 8'h85);
        rd("clr ram", OFF_DATA, 32'h20);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_INSTR, {3'b001, i[1:0], 1'b0, i[1:0]});
            check("func", {28'h0, bw_o, two_o, lhi_o, llo_o},
                  {28'h0, i[1:0], i[1:0]});
        end
        wr(OFF_INSTR, 8'h85);
        wr(OFF_DATA, 8'h5a);
        wr(OFF_INSTR, 8'h0f);
        wr(OFF_INSTR, 8'h85);
        clr <= 1'b0;
        repeat (1665) @(negedge clk_i);
        check("cursor", {24'h0, cur_cnt}, 32'h10);
        check("blink", {24'h0, on_cnt}, 32'h08);
        // scan code lags the sweep address by one cell
        for (int n = 0; n < 256 && scan_a !== 7'h06; n++) begin
            @(negedge clk_i);
        end
        check("scan char", {24'h0, scan_char}, 32'h5a);
        wr(OFF_INSTR, 8'h0b);
        check("disp", {31'h0, disp_o}, 32'h0);
        end_of_test();
    end
endmodule : cdcd_decoder_tb
